//--- rtl/mode_config_top.sv
// mode_config_top: resolution, power-down and power-saving mode timing
// with the pixel readout walker; registers reached over the serial port
// assumes motion_i and pixel inputs come from logic on core_clk_i
//
// Summary of operation
// - pixels are numbered from 0 top-right, down each column of 19, columns leftward.
// - resolution code 0..5 selects 1000, 250, 500, 1250, 1500 or 1750 cpi.
// - with the apply bit set the code is used and the fallback bit ignored.
// - with apply clear the fallback bit gives 500 cpi at 0, 1000 at 1; resets to 1.
// - after delay times 16 frames with no motion, run drops to rest1; delay resets to 0x46.
// - a write to the readout port rewinds it to pixel 0; reads walk in index order.
`timescale 1ns/1ns
`default_nettype none
module mode_config_top #(
  parameter int FRAME_CYCLES = mode_config_pkg::FRAME_CYCLES,
  parameter int REST1_UNIT_CYCLES = mode_config_pkg::REST1_UNIT_CYCLES
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic ncs_n_i,
  input wire logic sclk_i,
  input wire logic mosi_i,
  output logic miso_o,
  output logic miso_oe_n_o,
  input wire logic motion_i,
  input wire logic [6:0] pixel_data_i,
  input wire logic pixel_valid_i,
  output logic [8:0] pixel_index_o,
  output logic [4:0] pixel_row_o,
  output logic [4:0] pixel_col_o,
  output logic [10:0] cpi_o,
  output logic power_down_o,
  output logic rest1_o,
  output logic frame_o
);

  logic [6:0] addr;
  logic [7:0] wdata;
  logic wr_pulse;
  logic rd_pulse;
  logic [7:0] rdata;
  logic [7:0] res_power_q;
  logic [7:0] run_rest1_q;
  logic [7:0] rest1_interval_q;
  logic [8:0] index_q;
  logic [4:0] row_q;
  logic [4:0] col_right_q;
  mode_config_pkg::power_mode_t mode_q;
  logic [16:0] cyc_q;
  logic [7:0] units_q;
  logic [11:0] idle_frames_q;
  logic unit_done;
  logic frame_tick;
  logic [11:0] idle_target;

  serial_reg_port u_port (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .ncs_n_i(ncs_n_i),
    .sclk_i(sclk_i),
    .mosi_i(mosi_i),
    .miso_o(miso_o),
    .miso_oe_n_o(miso_oe_n_o),
    .addr_o(addr),
    .wdata_o(wdata),
    .wr_pulse_o(wr_pulse),
    .rd_pulse_o(rd_pulse),
    .rdata_i(rdata)
  );

  function automatic logic [10:0] code_to_cpi(input logic [2:0] code);
    unique case (code)
      mode_config_pkg::RES_CODE_250: code_to_cpi = mode_config_pkg::CPI_250;
      mode_config_pkg::RES_CODE_500: code_to_cpi = mode_config_pkg::CPI_500;
      mode_config_pkg::RES_CODE_1250: code_to_cpi = mode_config_pkg::CPI_1250;
      mode_config_pkg::RES_CODE_1500: code_to_cpi = mode_config_pkg::CPI_1500;
      mode_config_pkg::RES_CODE_1750: code_to_cpi = mode_config_pkg::CPI_1750;
      // codes 6 and 7 are undefined; fall back to the default rate
      default: code_to_cpi = mode_config_pkg::CPI_1000;
    endcase
  endfunction

  // register writes
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      res_power_q <= mode_config_pkg::RST_RES_POWER;
      run_rest1_q <= mode_config_pkg::RST_RUN_REST1;
      rest1_interval_q <= mode_config_pkg::RST_REST1_INTERVAL;
    end else if (wr_pulse) begin
      unique case (addr)
        mode_config_pkg::ADDR_RES_POWER: res_power_q <= wdata & mode_config_pkg::RES_POWER_WMASK;
        mode_config_pkg::ADDR_RUN_REST1: run_rest1_q <= wdata;
        mode_config_pkg::ADDR_REST1_INTERVAL: rest1_interval_q <= wdata;
        default: ;
      endcase
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    rdata = 8'h00;
    unique case (addr)
      mode_config_pkg::ADDR_PIXEL_READOUT: rdata = {pixel_valid_i, pixel_data_i};
      mode_config_pkg::ADDR_RES_POWER: rdata = res_power_q;
      mode_config_pkg::ADDR_RUN_REST1: rdata = run_rest1_q;
      mode_config_pkg::ADDR_REST1_INTERVAL: rdata = rest1_interval_q;
      default: rdata = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cpi_o <= mode_config_pkg::CPI_1000;
    end else if (res_power_q[mode_config_pkg::RES_APPLY_BIT]) begin
      cpi_o <= code_to_cpi(res_power_q[mode_config_pkg::RES_CODE_MSB:mode_config_pkg::RES_CODE_LSB]);
    end else begin
      cpi_o <= res_power_q[mode_config_pkg::FALLBACK_BIT] ? mode_config_pkg::CPI_1000 :
        mode_config_pkg::CPI_500;
    end
  end

  // rewind on write, step on read
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      index_q <= 9'h000;
      row_q <= 5'h00;
      col_right_q <= 5'h00;
    end else if (wr_pulse && addr == mode_config_pkg::ADDR_PIXEL_READOUT) begin
      index_q <= 9'h000;
      row_q <= 5'h00;
      col_right_q <= 5'h00;
    end else if (rd_pulse && addr == mode_config_pkg::ADDR_PIXEL_READOUT) begin
      // down the column, then one column left
      if (row_q != mode_config_pkg::ARRAY_LAST) begin
        row_q <= row_q + 5'h01;
        index_q <= index_q + 9'h001;
      end else if (col_right_q != mode_config_pkg::ARRAY_LAST) begin
        row_q <= 5'h00;
        col_right_q <= col_right_q + 5'h01;
        index_q <= index_q + 9'h001;
      end else begin
        // past pixel 360 the walk wraps to the origin
        row_q <= 5'h00;
        col_right_q <= 5'h00;
        index_q <= 9'h000;
      end
    end
  end

  assign pixel_index_o = index_q;
  assign pixel_row_o = row_q;
  // column counted from the left edge
  assign pixel_col_o = mode_config_pkg::ARRAY_LAST - col_right_q;

  // frame timer: run frames every FRAME_CYCLES, rest1 in whole units
  assign unit_done = (mode_q == mode_config_pkg::MODE_RUN) ?
    (cyc_q == 17'(FRAME_CYCLES - 1)) : (cyc_q == 17'(REST1_UNIT_CYCLES - 1));
  assign frame_tick = unit_done && (mode_q == mode_config_pkg::MODE_RUN ||
    (mode_q == mode_config_pkg::MODE_REST1 && units_q == rest1_interval_q));

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cyc_q <= 17'h00000;
      units_q <= 8'h00;
    end else if (mode_q == mode_config_pkg::MODE_POWER_DOWN) begin
      cyc_q <= 17'h00000;
      units_q <= 8'h00;
    end else if (unit_done) begin
      cyc_q <= 17'h00000;
      units_q <= frame_tick ? 8'h00 : units_q + 8'h01;
    end else begin
      cyc_q <= cyc_q + 17'h00001;
    end
  end

  assign idle_target = {run_rest1_q, 4'h0};

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_q <= mode_config_pkg::MODE_RUN;
      idle_frames_q <= 12'h000;
    end else if (res_power_q[mode_config_pkg::POWER_DOWN_BIT]) begin
      mode_q <= mode_config_pkg::MODE_POWER_DOWN;
      idle_frames_q <= 12'h000;
    end else begin
      unique case (mode_q)
        mode_config_pkg::MODE_POWER_DOWN: begin
          mode_q <= mode_config_pkg::MODE_RUN;
          idle_frames_q <= 12'h000;
        end
        mode_config_pkg::MODE_RUN: begin
          if (frame_tick) begin
            if (motion_i) begin
              idle_frames_q <= 12'h000;
            end else if (idle_frames_q + 12'h001 >= idle_target) begin
              mode_q <= mode_config_pkg::MODE_REST1;
              idle_frames_q <= 12'h000;
            end else begin
              idle_frames_q <= idle_frames_q + 12'h001;
            end
          end
        end
        mode_config_pkg::MODE_REST1: begin
          if (frame_tick && motion_i) begin
            mode_q <= mode_config_pkg::MODE_RUN;
          end
        end
        default: mode_q <= mode_config_pkg::MODE_RUN;
      endcase
    end
  end

  assign power_down_o = (mode_q == mode_config_pkg::MODE_POWER_DOWN);
  assign rest1_o = (mode_q == mode_config_pkg::MODE_REST1);
  assign frame_o = frame_tick;

endmodule // mode_config_top
`default_nettype wire

//--- rtl/mode_config_pkg.sv
// mode_config_pkg: register map, field layout, reset values and timing
// assumes a 10 MHz core clock and an 8-bit serial register space
package mode_config_pkg;

  // register offsets on the serial port
  localparam logic [6:0] ADDR_PIXEL_READOUT = 7'h0b;
  localparam logic [6:0] ADDR_RES_POWER = 7'h0d;
  localparam logic [6:0] ADDR_RUN_REST1 = 7'h0e;
  localparam logic [6:0] ADDR_REST1_INTERVAL = 7'h0f;

  // reset values
  localparam logic [7:0] RST_RES_POWER = 8'h01;
  localparam logic [7:0] RST_RUN_REST1 = 8'h46;
  localparam logic [7:0] RST_REST1_INTERVAL = 8'h00;

  // resolution_power_control fields
  localparam int FALLBACK_BIT = 0;
  localparam int POWER_DOWN_BIT = 1;
  localparam int RES_CODE_LSB = 2;
  localparam int RES_CODE_MSB = 4;
  localparam int RES_APPLY_BIT = 5;
  localparam logic [7:0] RES_POWER_WMASK = 8'h3f;

  // pixel readout port fields
  localparam int READOUT_VALID_BIT = 7;

  // resolution codes and counts per inch
  localparam logic [2:0] RES_CODE_1000 = 3'h0;
  localparam logic [2:0] RES_CODE_250 = 3'h1;
  localparam logic [2:0] RES_CODE_500 = 3'h2;
  localparam logic [2:0] RES_CODE_1250 = 3'h3;
  localparam logic [2:0] RES_CODE_1500 = 3'h4;
  localparam logic [2:0] RES_CODE_1750 = 3'h5;
  localparam logic [10:0] CPI_250 = 11'h0fa;
  localparam logic [10:0] CPI_500 = 11'h1f4;
  localparam logic [10:0] CPI_1000 = 11'h3e8;
  localparam logic [10:0] CPI_1250 = 11'h4e2;
  localparam logic [10:0] CPI_1500 = 11'h5dc;
  localparam logic [10:0] CPI_1750 = 11'h6d6;

  // image array geometry
  localparam int ARRAY_SIDE = 19;
  localparam logic [4:0] ARRAY_LAST = 5'h12;

  // downshift frames per register count
  localparam int DOWNSHIFT_SHIFT = 4;

  // timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int FRAME_PERIOD_NS = 444000;
  localparam int FRAME_CYCLES = FRAME_PERIOD_NS / CLK_PERIOD_NS;
  localparam int REST1_UNIT_NS = 10000000;
  localparam int REST1_UNIT_CYCLES = REST1_UNIT_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    MODE_RUN,
    MODE_REST1,
    MODE_POWER_DOWN
  } power_mode_t;

endpackage

//--- rtl/serial_reg_port.sv
// serial_reg_port: four-wire serial slave, address byte then data byte
// assumes sclk_i idles high, msb first, bit 7 of first byte set for write
`timescale 1ns/1ns
`default_nettype none
module serial_reg_port (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic ncs_n_i,
  input wire logic sclk_i,
  input wire logic mosi_i,
  output logic miso_o,
  output logic miso_oe_n_o,
  output logic [6:0] addr_o,
  output logic [7:0] wdata_o,
  output logic wr_pulse_o,
  output logic rd_pulse_o,
  input wire logic [7:0] rdata_i
);

  logic [2:0] sclk_sync_q;
  logic [1:0] ncs_sync_q;
  logic [1:0] mosi_sync_q;
  logic [4:0] bit_cnt_q;
  logic [7:0] in_sr_q;
  logic is_write_q;
  logic [7:0] out_sr_q;
  logic drive_q;
  logic sclk_rise;
  logic sclk_fall;
  logic selected;

  // stage 0 feeds only stage 1; edges come from stages 1 and 2
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sclk_sync_q <= 3'h7;
      ncs_sync_q <= 2'h3;
      mosi_sync_q <= 2'h0;
    end else begin
      sclk_sync_q <= {sclk_sync_q[1:0], sclk_i};
      ncs_sync_q <= {ncs_sync_q[0], ncs_n_i};
      mosi_sync_q <= {mosi_sync_q[0], mosi_i};
    end
  end

  assign selected = !ncs_sync_q[1];
  assign sclk_rise = selected && sclk_sync_q[1] && !sclk_sync_q[2];
  assign sclk_fall = selected && !sclk_sync_q[1] && sclk_sync_q[2];

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bit_cnt_q <= 5'h00;
      in_sr_q <= 8'h00;
      is_write_q <= 1'b0;
      addr_o <= 7'h00;
      wdata_o <= 8'h00;
      wr_pulse_o <= 1'b0;
      rd_pulse_o <= 1'b0;
    end else begin
      wr_pulse_o <= 1'b0;
      rd_pulse_o <= 1'b0;
      if (!selected) begin
        bit_cnt_q <= 5'h00;
      end else if (sclk_rise) begin
        in_sr_q <= {in_sr_q[6:0], mosi_sync_q[1]};
        bit_cnt_q <= bit_cnt_q + 5'h01;
        if (bit_cnt_q == 5'h07) begin
          is_write_q <= in_sr_q[6];
          addr_o <= {in_sr_q[5:0], mosi_sync_q[1]};
          rd_pulse_o <= !in_sr_q[6];
        end
        if (bit_cnt_q == 5'h0f) begin
          wdata_o <= {in_sr_q[6:0], mosi_sync_q[1]};
          wr_pulse_o <= is_write_q;
          bit_cnt_q <= 5'h00;
        end
      end
    end
  end

  // read data is taken in the pulse cycle, shifted out on falling edges
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_sr_q <= 8'h00;
      drive_q <= 1'b0;
      miso_o <= 1'b0;
    end else if (!selected) begin
      drive_q <= 1'b0;
    end else if (rd_pulse_o) begin
      out_sr_q <= rdata_i;
      drive_q <= 1'b1;
    end else if (sclk_fall && drive_q) begin
      miso_o <= out_sr_q[7];
      out_sr_q <= {out_sr_q[6:0], 1'b0};
    end
  end

  assign miso_oe_n_o = !drive_q;

endmodule // serial_reg_port
`default_nettype wire

//--- verification/mode_config_sva.sv
// mode_config_sva: port-level properties of mode_config_top
// assumes it is bound onto mode_config_top with the same frame parameters
`timescale 1ns/1ns
`default_nettype none
module mode_config_sva #(
  parameter int FRAME_CYCLES = 8,
  parameter int REST1_UNIT_CYCLES = 4
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic ncs_n_i,
  input wire logic miso_oe_n_o,
  input wire logic [8:0] pixel_index_o,
  input wire logic [4:0] pixel_row_o,
  input wire logic [4:0] pixel_col_o,
  input wire logic [10:0] cpi_o,
  input wire logic power_down_o,
  input wire logic rest1_o,
  input wire logic frame_o
);
  logic [15:0] gap_q;
  logic prev_run_q;
  // gap restarts on power-down, so wake-up frames are never judged
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) gap_q <= 16'h0;
    else if (frame_o || power_down_o) gap_q <= 16'h0;
    else gap_q <= gap_q + 16'h1;
  end
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) prev_run_q <= 1'b0;
    else if (power_down_o) prev_run_q <= 1'b0;
    else if (frame_o) prev_run_q <= !rest1_o;
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // synchronizer plus register: five idle cycles cover the release
  sequence ncs_idle_s;
    ncs_n_i [*5];
  endsequence
  sequence run_frame_s;
    frame_o && !rest1_o && prev_run_q;
  endsequence
  pix_map_a: assert property (
    pixel_index_o == 9'(pixel_row_o) + 9'd19 * (9'd18 - 9'(pixel_col_o)))
    else $error("pixel index off the array map");
  pix_range_a: assert property (
    pixel_row_o <= 5'h12 && pixel_col_o <= 5'h12) else $error("pixel row or column out of range");
  cpi_set_a: assert property (
    cpi_o inside {11'h0fa, 11'h1f4, 11'h3e8, 11'h4e2, 11'h5dc, 11'h6d6})
    else $error("resolution outside the legal set");
  cpi_reset_a: assert property (
    $rose(rst_n_i) |-> cpi_o == 11'h3e8) else $error("resolution not 1000 after reset");
  pd_quiet_a: assert property (
    power_down_o |-> !frame_o && !rest1_o) else $error("activity while powered down");
  pd_exit_a: assert property (
    $fell(power_down_o) |-> !rest1_o) else $error("power-down exit not to run");
  frame_pulse_a: assert property (
    frame_o |=> !frame_o) else $error("frame pulse longer than one cycle");
  run_gap_a: assert property (
    run_frame_s |-> gap_q == 16'(FRAME_CYCLES - 1)) else $error("run frame spacing wrong");
  rest_entry_a: assert property (
    $rose(rest1_o) |-> $past(frame_o)) else $error("rest1 entered between frames");
  oe_idle_a: assert property (
    ncs_idle_s |-> miso_oe_n_o) else $error("miso driven while deselected");
endmodule // mode_config_sva
bind mode_config_top mode_config_sva #(
  .FRAME_CYCLES(FRAME_CYCLES),
  .REST1_UNIT_CYCLES(REST1_UNIT_CYCLES)
) mode_config_sva_inst (.core_clk_i, .rst_n_i, .ncs_n_i, .miso_oe_n_o, .pixel_index_o,
  .pixel_row_o, .pixel_col_o, .cpi_o, .power_down_o, .rest1_o, .frame_o);
`default_nettype wire

//--- verification/serial_host_model.sv
// serial_host_model: microcontroller on the four-wire serial port
// assumes 800 ns serial clock idling high, msb first, device drives miso
`timescale 1ns/1ns
`default_nettype none
module serial_host_model (
  output logic ncs_n_o,
  output logic sclk_o,
  output logic mosi_o,
  input wire logic miso_i,
  input wire logic miso_oe_n_i
);
  initial begin
    ncs_n_o = 1'b1;
    sclk_o = 1'b1;
    mosi_o = 1'b0;
  end
  // miso sampled just before the next fall, where the bit surely stands
  task automatic frame(input logic [15:0] tx, output logic [7:0] rx);
    rx = 8'h00;
    // entered one step after a core edge, so every pin change keeps that phase
    ncs_n_o = 1'b0;
    #400;
    for (int i = 15; i >= 0; i--) begin
      sclk_o = 1'b0;
      if (i < 7) rx = {rx[6:0], miso_oe_n_i ? ~rx[0] : miso_i};
      mosi_o = tx[i];
      #400;
      sclk_o = 1'b1;
      #400;
    end
    rx = {rx[6:0], miso_oe_n_i ? ~rx[0] : miso_i};
    ncs_n_o = 1'b1;
    // released data line must not keep its last level
    mosi_o = ~mosi_o;
    #800;
  endtask
  task automatic access(input logic wr, input logic [6:0] ad, input logic [7:0] d,
      output logic [7:0] rx);
    logic [7:0] dummy;
    if (wr && ad == 7'h0e && d == 8'h00) d = 8'h01;
    frame({wr, ad, d}, rx);
    if (ad == 7'h0d) frame({1'b1, 7'h21, 8'h10}, dummy);
  endtask
endmodule // serial_host_model
`default_nettype wire

//--- verification/test_mouse_sensor_mode_config.sv
// test_mouse_sensor_mode_config: self-checking bench for mode_config_top
// assumes the host model and bound checker are compiled before it
`timescale 1ns/1ns
`default_nettype none
module test_mouse_sensor_mode_config;
  logic core_clk_i, rst_n_i, ncs_n_i, sclk_i, mosi_i, miso_o, miso_oe_n_o;
  logic motion_i, pixel_valid_i, power_down_o, rest1_o, frame_o;
  logic [6:0] pixel_data_i;
  logic [8:0] pixel_index_o;
  logic [4:0] pixel_row_o, pixel_col_o;
  logic [10:0] cpi_o;
  logic [7:0] rx;
  logic [31:0] seed = 32'h0b44;
  int failures = 0;
  int samples_checked = 0;
  int mdl[int];
  int cpi_tab[8] = '{1000, 250, 500, 1250, 1500, 1750, 1000, 1000};
  int n, k, last, gap;
  // short frame and rest1 unit keep the run small
  mode_config_top #(.FRAME_CYCLES(8), .REST1_UNIT_CYCLES(4)) mode_config_top_inst (
    .core_clk_i, .rst_n_i, .ncs_n_i, .sclk_i, .mosi_i, .miso_o, .miso_oe_n_o, .motion_i,
    .pixel_data_i, .pixel_valid_i, .pixel_index_o, .pixel_row_o, .pixel_col_o, .cpi_o,
    .power_down_o, .rest1_o, .frame_o);
  serial_host_model serial_host_model_inst (.ncs_n_o(ncs_n_i), .sclk_o(sclk_i),
    .mosi_o(mosi_i), .miso_i(miso_o), .miso_oe_n_i(miso_oe_n_o));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic int exp_cpi(input int c);
    return c[5] ? cpi_tab[c[4:2]] : (c[0] ? 1000 : 500);
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    serial_host_model_inst.access(1'b1, a, d, rx);
    if (a == 7'h0d) mdl[13] = d & 8'h3f;
    else if (a inside {7'h0e, 7'h0f}) mdl[a] = d;
    @(posedge core_clk_i);
    #1;
    check("cpi", 32'(cpi_o), exp_cpi(mdl[13]));
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    serial_host_model_inst.access(1'b0, a, 8'h00, rx);
    @(posedge core_clk_i);
    #1;
    check("rdata", 32'(rx), 32'(exp));
  endtask
  task automatic rdm(input logic [6:0] a);
    rd(a, mdl.exists(a) ? 8'(mdl[a]) : 8'h00);
  endtask
  initial begin
    core_clk_i = 1'b0;
    forever #50 core_clk_i = ~core_clk_i;
  end
  initial begin
    repeat (30000) @(posedge core_clk_i);
    failures++;
    print_verdict();
  end
  initial begin
    rst_n_i = 1'b0;
    motion_i = 1'b1;
    pixel_valid_i = 1'b0;
    pixel_data_i = 7'h00;
    mdl[13] = 8'h01;
    mdl[14] = 8'h46;
    mdl[15] = 8'h00;
    repeat (2) @(posedge core_clk_i);
    #1;
    rst_n_i = 1'b1;
    repeat (2) @(posedge core_clk_i);
    #1;
    check("cpi", 32'(cpi_o), 32'd1000);
    for (n = 13; n <= 16; n++) rdm(7'(n == 16 ? 32 : n));
    for (n = 0; n < 8; n++) begin
      wr(7'h0d, 8'(8'he0 | (n << 2) | (n & 1)));
      rdm(7'h0d);
    end
    for (n = 0; n < 2; n++) wr(7'h0d, 8'(8'h14 | n));
    wr(7'h0d, 8'h03);
    k = 0;
    repeat (40) begin
      @(posedge core_clk_i);
      #1;
      k += frame_o;
    end
    check("pd_frames", k, 0);
    check("pd", 32'(power_down_o), 32'd1);
    wr(7'h0d, 8'h01);
    check("pd", 32'(power_down_o), 32'd0);
    wr(7'h0f, 8'h02);
    wr(7'h0e, 8'h01);
    rdm(7'h0f);
    motion_i = 1'b0;
    k = 0;
    last = 0;
    gap = 0;
    // sample before the edge: the frame shown now is judged with motion low
    for (n = 0; n < 400; n++) begin
      if (frame_o === 1'b1 && rest1_o !== 1'b1) k++;
      if (frame_o === 1'b1 && rest1_o === 1'b1) begin
        gap = n - last;
        last = n;
      end
      @(posedge core_clk_i);
      #1;
    end
    check("run_frames", k, 16);
    check("rest1_gap", gap, 12);
    motion_i = 1'b1;
    repeat (40) @(posedge core_clk_i);
    #1;
    check("rest1", 32'(rest1_o), 32'd0);
    wr(7'h0b, 8'h5a);
    check("ptr", 32'(pixel_index_o), 32'd0);
    for (n = 1; n <= 21; n++) begin
      seed = lfsr(seed);
      pixel_data_i = seed[6:0];
      pixel_valid_i = seed[7];
      rd(7'h0b, seed[7:0]);
      check("ptr", 32'(pixel_index_o), n);
      if (n == 20) check("col", 32'(pixel_col_o), 32'd17);
    end
    // pointer now away from the origin, so the rewind can be seen
    wr(7'h0b, 8'h00);
    check("ptr", 32'(pixel_index_o), 32'd0);
    check("col", 32'(pixel_col_o), 32'd18);
    print_verdict();
  end
endmodule // test_mouse_sensor_mode_config
`default_nettype wire
